/* ottf_params.svh */
`ifndef OTTF_PARAMS_SVH
`define OTTF_PARAMS_SVH
`define OTTF_ADDR_W 16
`define OTTF_DATA_W 8
`define OTTF_FIFO_DEPTH 8
`define OTTF_CNT_W 4
`define OTTF_CNT_FULL 4'h8
`define OTTF_COF_DELAY 2'h2
`define OTTF_TRK_W 3
`define OTTF_TRK_ZERO 3'h0
`define OTTF_TRK_MSB 2
`define OTTF_DIR_WRITE 1'h0
`endif

/* ottf_pkg.sv */
package ottf_pkg;
   typedef enum logic [3:0] {
      OTTF_A_ONLY = 4'h0,
      OTTF_A_OR_B = 4'h1,
      OTTF_A_THEN_B = 4'h2,
      OTTF_EVENT_B = 4'h3,
      OTTF_A_THEN_EVENT_B = 4'h4,
      OTTF_A_AND_DATA = 4'h5,
      OTTF_A_AND_NOT_DATA = 4'h6,
      OTTF_INSIDE = 4'h7,
      OTTF_OUTSIDE = 4'h8
   } ottf_mode_t;
   typedef enum logic [1:0] {
      OTTF_IDLE = 2'h0,
      OTTF_RUN = 2'h1,
      OTTF_DONE = 2'h2
   } ottf_state_t;
endpackage

/* ottf_fifo.sv */
`timescale 1ns/100ps
`include "ottf_params.svh"
module ottf_fifo #(
   parameter int WIDTH = `OTTF_ADDR_W,
   parameter int DEPTH = `OTTF_FIFO_DEPTH,
   parameter int CW = `OTTF_CNT_W
) (
   // Clock, reset, enable and flush
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic flush_in,
   // Fill side
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   // Drain side
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out,
   output logic [CW-1:0] count_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rp, wp, next_rp, next_wp;
   logic [CW-1:0] cnt, next_cnt;
   logic push, pop;
   always_comb begin
      push = wr_valid_in && wr_ready_out;
      pop = rd_valid_out && rd_ready_in;
      next_rp = rp;
      next_wp = wp;
      next_cnt = cnt;
      if (flush_in) begin
         next_rp = '0;
         next_wp = '0;
         next_cnt = '0;
      end else begin
         if (push) next_wp = (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
         if (pop) next_rp = (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
         if (push && !pop) next_cnt = cnt + 1'b1;
         if (pop && !push) next_cnt = cnt - 1'b1;
      end
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rp <= '0;
         wp <= '0;
         cnt <= '0;
      end else if (ce_in) begin
         rp <= next_rp;
         wp <= next_wp;
         cnt <= next_cnt;
      end
   end
   always_ff @(posedge clock_in) begin
      if (ce_in && push && !flush_in) mem[wp] <= wr_data_in;
   end
   assign wr_ready_out = (cnt != CW'(DEPTH)) || rd_ready_in;
   assign rd_valid_out = (cnt != '0);
   assign rd_data_out = mem[rp];
   assign count_out = cnt;
endmodule

/* ottf_core.sv */
`timescale 1ns/100ps
`include "ottf_params.svh"
// Notes on behaviour
// - Two 16-bit comparators A and B, optionally direction and exec gated.
// - Each comparator ignores direction or needs a programmed direction.
// - Exec-qualified match triggers only when its opcode actually executes.
// - Comparators support >= and <= for inside and outside range modes.
// - All matches are suppressed during serial debug controller accesses.
// - A compares address; B compares address or 8-bit data by mode.
// - Data compare uses write bus if A direction-qualified as write.
// - Match may request break, store data, begin or end flow capture.
// - Eight-stage capture FIFO holds addresses or data.
// - Valid count tracks stored words; value 8 means full.
// - Manual halt before full leaves entries offset by one position.
// - High byte read first; low byte read advances the FIFO.
// - Event modes store 8-bit data; low byte read advances.
// - Flow addresses at or within two cycles after begin trigger dropped.
// - End trace stores a triggering flow event as last entry.
// - When not armed, low byte read loads last fetched opcode address.
// - Taken conditional branch stores its opcode address; always/never none.
// - Indirect jumps, calls, interrupts and returns store destination.
// - Force break: CPU finishes instruction, then acts on request.
// - Tag break raises break_tag_out on the trigger (A match in data modes); it waits for execution only when exec qualify is selected.
// - Each comparator has its own opcode tracker.
// - Arm sets active flag, clears hit flags and valid count.
module ottf_core #(
   parameter int TRK_DEPTH = `OTTF_TRK_W
) (
   // Clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // Setup
   input wire logic arm_write_in,
   input wire logic arm_value_in,
   input wire logic [3:0] trigger_mode_in,
   input wire logic begin_trace_in,
   input wire logic exec_qualify_select_in,
   input wire logic break_enable_in,
   input wire logic break_tag_in,
   input wire logic dir_qualify_enable_a_in,
   input wire logic dir_match_value_a_in,
   input wire logic dir_qualify_enable_b_in,
   input wire logic dir_match_value_b_in,
   input wire logic [15:0] compare_a_in,
   input wire logic [15:0] compare_b_in,
   // CPU bus
   input wire logic [15:0] cpu_addr_in,
   input wire logic cpu_read_in,
   input wire logic [7:0] cpu_rdata_in,
   input wire logic [7:0] cpu_wdata_in,
   input wire logic bus_cycle_in,
   input wire logic opcode_fetch_in,
   input wire logic opcode_exec_in,
   input wire logic queue_flush_in,
   input wire logic [15:0] last_opcode_addr_in,
   input wire logic cof_valid_in,
   input wire logic [15:0] cof_addr_in,
   input wire logic debug_access_in,
   // FIFO read ports
   input wire logic fifo_read_high_in,
   input wire logic fifo_read_low_in,
   // Status and requests
   output logic run_active_flag_out,
   output logic comparator_a_hit_flag_out,
   output logic comparator_b_hit_flag_out,
   output logic [3:0] fifo_valid_count_out,
   output logic [7:0] fifo_data_out,
   output logic break_force_out,
   output logic break_tag_out
);
   localparam int QW = $clog2(TRK_DEPTH + 1);
   ottf_pkg::ottf_state_t st, next_st;
   logic hit_a, hit_b, next_hit_a, next_hit_b, a_seen, next_a_seen;
   logic [1:0] hold, next_hold;
   logic [TRK_DEPTH-1:0] trk_a, trk_b, next_trk_a, next_trk_b;
   logic [7:0] dout, next_dout;
   logic bf, bt, next_bf, next_bt;
   logic [3:0] cnt_q;
   logic eq_a, eq_b, ge_a, le_b, dir_a, dir_b, d_eq, raw_a, raw_b;
   logic q_a, q_b, trig, ev_mode, full_mode, run_q, next_run;
   logic [QW-1:0] qn, next_qn;
   logic [7:0] dsel;
   logic [15:0] f_in, f_out;
   logic f_push, f_pop, f_rdy, f_vld, flush;
   ottf_pkg::ottf_mode_t mode;

   function automatic logic dir_ok(input logic en, input logic val,
                                   input logic rd);
      dir_ok = !en || (val == rd);
   endfunction

   // Opcode tracker: a mark joins the queue tail on fetch and leaves the
   // head on execute, so only an executed marked opcode can fire
   function automatic logic [TRK_DEPTH-1:0] trk_step(
      input logic [TRK_DEPTH-1:0] t, input logic [QW-1:0] n,
      input logic mark);
      logic [TRK_DEPTH-1:0] r;
      logic [QW-1:0] k;
      r = t;
      k = n;
      if (opcode_exec_in && n != '0) begin
         r = t >> 1;
         k = n - 1'b1;
      end
      if (opcode_fetch_in && k != QW'(TRK_DEPTH)) r[k] = mark;
      if (queue_flush_in) r = '0;
      trk_step = r;
   endfunction

   always_comb begin
      mode = ottf_pkg::ottf_mode_t'(trigger_mode_in);
      ev_mode = (mode == ottf_pkg::OTTF_EVENT_B) ||
                (mode == ottf_pkg::OTTF_A_THEN_EVENT_B);
      full_mode = (mode == ottf_pkg::OTTF_A_AND_DATA) ||
                  (mode == ottf_pkg::OTTF_A_AND_NOT_DATA);
      eq_a = cpu_addr_in == compare_a_in;
      eq_b = cpu_addr_in == compare_b_in;
      ge_a = cpu_addr_in >= compare_a_in;
      le_b = cpu_addr_in <= compare_b_in;
      dir_a = dir_ok(dir_qualify_enable_a_in, dir_match_value_a_in,
                     cpu_read_in);
      dir_b = dir_ok(dir_qualify_enable_b_in, dir_match_value_b_in,
                     cpu_read_in);
      dsel = (dir_qualify_enable_a_in &&
              dir_match_value_a_in == `OTTF_DIR_WRITE) ?
             cpu_wdata_in : cpu_rdata_in;
      d_eq = dsel == compare_b_in[7:0];
      raw_a = bus_cycle_in && !debug_access_in && dir_a;
      raw_b = bus_cycle_in && !debug_access_in && dir_b;
      unique case (mode)
         ottf_pkg::OTTF_INSIDE: begin
            raw_a = raw_a && ge_a && le_b;
            raw_b = 1'b0;
         end
         ottf_pkg::OTTF_OUTSIDE: begin
            raw_a = raw_a && !(ge_a && le_b);
            raw_b = 1'b0;
         end
         ottf_pkg::OTTF_A_AND_DATA,
         ottf_pkg::OTTF_A_AND_NOT_DATA: begin
            raw_b = raw_a && eq_a &&
                    (d_eq == (mode == ottf_pkg::OTTF_A_AND_DATA));
            raw_a = raw_a && eq_a;
         end
         default: begin
            raw_a = raw_a && eq_a;
            raw_b = raw_b && eq_b;
         end
      endcase
      next_trk_a = trk_step(trk_a, qn, raw_a && opcode_fetch_in);
      next_trk_b = trk_step(trk_b, qn, raw_b && opcode_fetch_in);
      next_qn = qn;
      if (opcode_exec_in && qn != '0) next_qn = qn - 1'b1;
      if (opcode_fetch_in && next_qn != QW'(TRK_DEPTH))
         next_qn = next_qn + 1'b1;
      if (queue_flush_in) next_qn = '0;
      q_a = exec_qualify_select_in ?
            (opcode_exec_in && trk_a[0]) : raw_a;
      q_b = exec_qualify_select_in ?
            (opcode_exec_in && trk_b[0]) : raw_b;
      unique case (mode)
         ottf_pkg::OTTF_A_ONLY, ottf_pkg::OTTF_INSIDE,
         ottf_pkg::OTTF_OUTSIDE: trig = q_a;
         ottf_pkg::OTTF_A_OR_B: trig = q_a || q_b;
         ottf_pkg::OTTF_A_THEN_B,
         ottf_pkg::OTTF_A_THEN_EVENT_B: trig = a_seen && q_b;
         ottf_pkg::OTTF_EVENT_B: trig = q_b;
         ottf_pkg::OTTF_A_AND_DATA,
         ottf_pkg::OTTF_A_AND_NOT_DATA: trig = q_b;
         default: trig = 1'b0;
      endcase
      next_st = st;
      next_hit_a = hit_a || (st == ottf_pkg::OTTF_RUN && q_a);
      next_hit_b = hit_b || (st == ottf_pkg::OTTF_RUN && q_b);
      next_a_seen = a_seen || (st == ottf_pkg::OTTF_RUN && q_a);
      next_hold = (hold != 2'h0) ? hold - 2'h1 : 2'h0;
      f_push = 1'b0;
      f_in = cof_addr_in;
      flush = 1'b0;
      unique case (st)
         ottf_pkg::OTTF_IDLE: begin
            if (fifo_read_low_in) begin
               f_push = 1'b1;
               f_in = last_opcode_addr_in;
            end
         end
         ottf_pkg::OTTF_RUN: begin
            if (ev_mode) begin
               f_push = trig;
               f_in = {8'h00, dsel};
            end else if (begin_trace_in) begin
               if (a_seen && !trig) f_push = cof_valid_in && hold == 2'h0;
               if (trig && !a_seen) next_hold = `OTTF_COF_DELAY;
            end else begin
               f_push = cof_valid_in;
               if (trig) next_st = ottf_pkg::OTTF_DONE;
            end
            if (cnt_q == `OTTF_CNT_FULL && (ev_mode || begin_trace_in))
               next_st = ottf_pkg::OTTF_DONE;
         end
         ottf_pkg::OTTF_DONE: ;
         default: next_st = ottf_pkg::OTTF_IDLE;
      endcase
      if (begin_trace_in && !ev_mode && st == ottf_pkg::OTTF_RUN &&
          trig) next_a_seen = 1'b1;
      if (arm_write_in && !arm_value_in)
         next_st = ottf_pkg::OTTF_IDLE;
      if (arm_write_in && arm_value_in) begin
         next_st = ottf_pkg::OTTF_RUN;
         next_hit_a = 1'b0;
         next_hit_b = 1'b0;
         next_a_seen = 1'b0;
         next_hold = 2'h0;
         flush = 1'b1;
      end
      if (!f_rdy) f_push = 1'b0;
      // While idle the FIFO fills as a delay line before it shifts
      f_pop = fifo_read_low_in && f_vld &&
              (st != ottf_pkg::OTTF_IDLE || cnt_q == `OTTF_CNT_FULL);
      next_dout = dout;
      if (fifo_read_high_in) next_dout = f_out[15:8];
      if (fifo_read_low_in) next_dout = f_out[7:0];
      next_bf = st == ottf_pkg::OTTF_RUN && break_enable_in &&
                !break_tag_in && trig;
      next_bt = st == ottf_pkg::OTTF_RUN && break_enable_in &&
                break_tag_in && (full_mode ? q_a : trig);
      next_run = (next_st == ottf_pkg::OTTF_RUN);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st <= ottf_pkg::OTTF_IDLE;
         hit_a <= 1'b0;
         hit_b <= 1'b0;
         a_seen <= 1'b0;
         hold <= 2'h0;
         trk_a <= '0;
         trk_b <= '0;
         dout <= 8'h00;
         bf <= 1'b0;
         bt <= 1'b0;
         run_q <= 1'b0;
         qn <= '0;
      end else if (ce_in) begin
         st <= next_st;
         hit_a <= next_hit_a;
         hit_b <= next_hit_b;
         a_seen <= next_a_seen;
         hold <= next_hold;
         trk_a <= next_trk_a;
         trk_b <= next_trk_b;
         dout <= next_dout;
         bf <= next_bf;
         bt <= next_bt;
         run_q <= next_run;
         qn <= next_qn;
      end
   end

   ottf_fifo #(
      .WIDTH(`OTTF_ADDR_W),
      .DEPTH(`OTTF_FIFO_DEPTH),
      .CW(`OTTF_CNT_W)
   ) u_fifo (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .flush_in(flush),
      .wr_valid_in(f_push),
      .wr_ready_out(f_rdy),
      .wr_data_in(f_in),
      .rd_valid_out(f_vld),
      .rd_ready_in(f_pop),
      .rd_data_out(f_out),
      .count_out(cnt_q)
   );

   assign run_active_flag_out = run_q;
   assign comparator_a_hit_flag_out = hit_a;
   assign comparator_b_hit_flag_out = hit_b;
   assign fifo_valid_count_out = cnt_q;
   assign fifo_data_out = dout;
   assign break_force_out = bf;
   assign break_tag_out = bt;

   arm_clears_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      ce_in && arm_write_in && arm_value_in |=>
      !hit_a && !hit_b && cnt_q == 4'h0 && run_active_flag_out)
      else $error("arm did not clear flags");
   debug_mask_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      debug_access_in |-> !raw_a && !raw_b)
      else $error("match during debug access");
   count_max_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      cnt_q <= `OTTF_CNT_FULL)
      else $error("fifo count above full");
   force_break_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      ce_in && st == ottf_pkg::OTTF_RUN && break_enable_in &&
      !break_tag_in && trig |=> bf)
      else $error("force break missing");
   exec_gate_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      exec_qualify_select_in && !opcode_exec_in |-> !q_a && !q_b)
      else $error("exec trigger without execute");
   wdata_sel_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      dir_qualify_enable_a_in && !dir_match_value_a_in |->
      dsel == cpu_wdata_in)
      else $error("wrong data bus");
   cof_hold_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      ce_in && hold != 2'h0 && !ev_mode && !arm_write_in |=>
      $past(cnt_q) == cnt_q || $past(fifo_read_low_in))
      else $error("flow stored during delay");
   low_pop_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      fifo_read_low_in && f_vld && st != ottf_pkg::OTTF_IDLE |-> f_pop)
      else $error("low read did not advance");
   idle_fill_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      st == ottf_pkg::OTTF_IDLE && fifo_read_low_in |->
      f_pop == (cnt_q == `OTTF_CNT_FULL))
      else $error("idle read shifted wrongly");
   tag_break_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      ce_in && st == ottf_pkg::OTTF_RUN && break_enable_in &&
      break_tag_in && full_mode && q_a |=> bt)
      else $error("tag break missing");
   event_push_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      st == ottf_pkg::OTTF_RUN && ev_mode && trig && f_rdy |-> f_push)
      else $error("event data not stored");
   full_stop_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      ce_in && st == ottf_pkg::OTTF_RUN && (ev_mode || begin_trace_in) &&
      cnt_q == `OTTF_CNT_FULL && !arm_write_in |=> !run_active_flag_out)
      else $error("run did not end when full");
   queue_bound_a: assert property (
      @(posedge clock_in) disable iff (rst_in)
      qn <= QW'(TRK_DEPTH))
      else $error("tracker queue overrun");
endmodule

/* ottf_cpu_model.sv */
`timescale 1ns/100ps
module ottf_cpu_model (
   // Clock
   input wire logic clock_in,
   // CPU bus seen by the trace unit
   output logic [15:0] addr_out,
   output logic read_out,
   output logic [7:0] rdata_out,
   output logic [7:0] wdata_out,
   output logic cycle_out,
   output logic dbg_access_out,
   // Instruction queue
   output logic fetch_out,
   output logic exec_out,
   output logic flush_out,
   output logic [15:0] last_op_out,
   // Change of flow
   output logic cof_valid_out,
   output logic [15:0] cof_addr_out
);
   initial begin
      {addr_out, read_out, rdata_out, wdata_out} = 33'h0;
      {cycle_out, dbg_access_out, fetch_out, exec_out, flush_out} = 5'h0;
      {last_op_out, cof_valid_out, cof_addr_out} = 33'h0;
   end

   // One bus cycle, entered just after a rising edge
   task automatic bus(input logic [15:0] a, input logic rd,
      input logic [7:0] rdat, input logic [7:0] wdat, input logic dbg,
      input logic fet);
      {addr_out, read_out, rdata_out, wdata_out} <= {a, rd, rdat, wdat};
      {cycle_out, dbg_access_out, fetch_out} <= {1'b1, dbg, fet};
      if (fet) begin
         last_op_out <= a;
      end
      @(posedge clock_in);
      // Idle lines show the inverse so no stale value can match
      {addr_out, rdata_out, wdata_out} <= {~a, ~rdat, ~wdat};
      {cycle_out, dbg_access_out, fetch_out} <= 3'h0;
      @(posedge clock_in);
   endtask

   task automatic cof(input logic [15:0] a);
      {cof_valid_out, cof_addr_out} <= {1'b1, a};
      @(posedge clock_in);
      {cof_valid_out, cof_addr_out} <= {1'b0, ~a};
      @(posedge clock_in);
   endtask

   task automatic op(input logic e, input logic f);
      {exec_out, flush_out} <= {e, f};
      @(posedge clock_in);
      {exec_out, flush_out} <= 2'h0;
      @(posedge clock_in);
   endtask
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
`include "ottf_params.svh"
module tb_top;
   logic clock_in, rst_in, ce_in, arm_write_in, arm_value_in;
   logic [3:0] trigger_mode_in;
   logic begin_trace_in, exec_qualify_select_in, break_enable_in;
   logic break_tag_in, dir_qualify_enable_a_in, dir_match_value_a_in;
   logic dir_qualify_enable_b_in, dir_match_value_b_in;
   logic [15:0] compare_a_in, compare_b_in, cpu_addr_in;
   logic [15:0] last_opcode_addr_in, cof_addr_in;
   logic cpu_read_in, bus_cycle_in, opcode_fetch_in, opcode_exec_in;
   logic queue_flush_in, cof_valid_in, debug_access_in;
   logic [7:0] cpu_rdata_in, cpu_wdata_in, fifo_data_out, d;
   logic fifo_read_high_in, fifo_read_low_in;
   logic run_active_flag_out, comparator_a_hit_flag_out;
   logic comparator_b_hit_flag_out, break_force_out, break_tag_out;
   logic [3:0] fifo_valid_count_out;
   int mismatches, samples_checked, cycles, brk, tg;

   ottf_core u_dut (.*);
   ottf_cpu_model u_cpu (.clock_in, .addr_out(cpu_addr_in),
      .read_out(cpu_read_in), .rdata_out(cpu_rdata_in),
      .wdata_out(cpu_wdata_in), .cycle_out(bus_cycle_in),
      .dbg_access_out(debug_access_in), .fetch_out(opcode_fetch_in),
      .exec_out(opcode_exec_in), .flush_out(queue_flush_in),
      .last_op_out(last_opcode_addr_in), .cof_valid_out(cof_valid_in),
      .cof_addr_out(cof_addr_in));

   always #20 clock_in = ~clock_in;

   always @(posedge clock_in) begin
      cycles++;
      if (break_force_out === 1'b1) begin
         brk++;
      end
      if (break_tag_out === 1'b1) begin
         tg++;
      end
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   task automatic arm(input logic [3:0] m, input logic v);
      {trigger_mode_in, arm_write_in, arm_value_in} <= {m, 1'b1, v};
      @(posedge clock_in);
      arm_write_in <= 1'b0;
      @(posedge clock_in);
   endtask

   // Host read of one FIFO byte port
   task automatic rd(input logic hi);
      {fifo_read_high_in, fifo_read_low_in} <= {hi, !hi};
      @(posedge clock_in);
      {fifo_read_high_in, fifo_read_low_in} <= 2'h0;
      @(posedge clock_in);
      d = fifo_data_out;
   endtask

   // Arm, run one bus cycle and count the force breaks it raises
   task automatic brk_case(input logic [3:0] m, input logic [15:0] a,
      input logic r, input logic [7:0] rdat, input logic [7:0] wdat,
      input int n);
      arm(m, 1'b1);
      brk = 0;
      u_cpu.bus(a, r, rdat, wdat, 1'b0, 1'b0);
      tick(3);
      check(16'(brk), 16'(n));
   endtask

   task automatic t_reset();
      check({1'b0, run_active_flag_out, comparator_a_hit_flag_out,
         comparator_b_hit_flag_out, fifo_valid_count_out, fifo_data_out},
         16'h0000);
   endtask

   task automatic t_profile();
      u_cpu.bus(16'h2468, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
      rd(1'b0);
      check(16'(fifo_valid_count_out), 16'h0001);
      repeat (7) rd(1'b0);
      check(16'(fifo_valid_count_out), 16'h0008);
      rd(1'b1);
      check(16'(d), 16'h0024);
   endtask

   task automatic t_fill();
      compare_a_in <= 16'hffff;
      arm(4'h0, 1'b1);
      check(16'(run_active_flag_out), 16'h0001);
      check(16'(fifo_valid_count_out), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         u_cpu.cof(16'h1000 + 16'(i) * 16'h0111);
         if (i == 1) begin
            tick(1);
            check(16'(fifo_valid_count_out), 16'h0002);
         end
      end
      tick(1);
      check(16'(fifo_valid_count_out), 16'(`OTTF_CNT_FULL));
      for (int i = 0; i < 8; i++) begin
         rd(1'b1);
         check(16'(d), 16'(8'h10 + 8'(i)));
         rd(1'b0);
         check(16'(d), 16'(8'(16'(i) * 16'h0011)));
      end
      check(16'(fifo_valid_count_out), 16'h0000);
   endtask

   task automatic t_event();
      {compare_b_in, begin_trace_in} <= {16'h0040, 1'b1};
      arm(4'h3, 1'b1);
      u_cpu.bus(16'h0040, 1'b1, 8'h5a, 8'h00, 1'b0, 1'b0);
      u_cpu.bus(16'h0040, 1'b1, 8'h33, 8'h00, 1'b1, 1'b0);
      u_cpu.bus(16'h0041, 1'b1, 8'h77, 8'h00, 1'b0, 1'b0);
      u_cpu.bus(16'h0040, 1'b1, 8'hc3, 8'h00, 1'b0, 1'b0);
      tick(1);
      check(16'(fifo_valid_count_out), 16'h0002);
      rd(1'b0);
      check(16'(d), 16'h005a);
      rd(1'b0);
      check(16'(d), 16'h00c3);
   endtask

   task automatic t_breaks();
      {begin_trace_in, break_enable_in} <= 2'h1;
      {compare_a_in, compare_b_in} <= {16'h0080, 16'h00c3};
      {dir_qualify_enable_a_in, dir_match_value_a_in} <= 2'h2;
      brk_case(4'h5, 16'h0080, 1'b0, 8'h00, 8'hc3, 1);
      check(16'({comparator_a_hit_flag_out, comparator_b_hit_flag_out}),
         16'h0003);
      brk_case(4'h5, 16'h0080, 1'b0, 8'hc3, 8'h00, 0);
      dir_qualify_enable_a_in <= 1'b0;
      brk_case(4'h5, 16'h0080, 1'b1, 8'hc3, 8'h00, 1);
      brk_case(4'h6, 16'h0080, 1'b1, 8'h11, 8'h00, 1);
      {compare_a_in, compare_b_in} <= {16'h0100, 16'h01ff};
      brk_case(4'h7, 16'h0100, 1'b1, 8'h00, 8'h00, 1);
      brk_case(4'h7, 16'h0200, 1'b1, 8'h00, 8'h00, 0);
      brk_case(4'h8, 16'h0200, 1'b1, 8'h00, 8'h00, 1);
      brk_case(4'h8, 16'h01ff, 1'b1, 8'h00, 8'h00, 0);
      break_tag_in <= 1'b1;
      tg = 0;
      brk_case(4'h5, 16'h0100, 1'b1, 8'h00, 8'h00, 0);
      check(16'(tg), 16'h0001);
      break_tag_in <= 1'b0;
   endtask

   task automatic t_begin();
      {compare_a_in, begin_trace_in} <= {16'h0500, 1'b1};
      arm(4'h0, 1'b1);
      fork
         u_cpu.bus(16'h0500, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
         u_cpu.cof(16'h0a00);
      join
      u_cpu.cof(16'h0b00);
      u_cpu.cof(16'h0c00);
      tick(1);
      check(16'(fifo_valid_count_out), 16'h0001);
      rd(1'b1);
      check(16'(d), 16'h000c);
      begin_trace_in <= 1'b0;
      arm(4'h0, 1'b1);
      fork
         u_cpu.bus(16'h0500, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
         u_cpu.cof(16'h0d00);
      join
      tick(1);
      check(16'(fifo_valid_count_out), 16'h0001);
      check(16'(run_active_flag_out), 16'h0000);
   endtask

   task automatic t_exec();
      {exec_qualify_select_in, compare_a_in} <= {1'b1, 16'h0300};
      arm(4'h0, 1'b1);
      brk = 0;
      u_cpu.bus(16'h0300, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
      u_cpu.op(1'b0, 1'b1);
      tick(4);
      check(16'(brk), 16'h0000);
      arm(4'h0, 1'b1);
      u_cpu.bus(16'h0300, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
      repeat (3) u_cpu.op(1'b1, 1'b0);
      tick(2);
      check(16'(brk != 0), 16'h0001);
   endtask

   initial begin
      {clock_in, rst_in, ce_in, arm_write_in, arm_value_in} = 5'h06;
      {trigger_mode_in, begin_trace_in, exec_qualify_select_in} = 6'h0;
      {break_enable_in, break_tag_in, dir_qualify_enable_a_in} = 3'h0;
      {dir_match_value_a_in, dir_qualify_enable_b_in} = 2'h0;
      {dir_match_value_b_in, compare_a_in, compare_b_in} = 33'h0;
      {fifo_read_high_in, fifo_read_low_in, arm_value_in} = 3'h0;
      {mismatches, samples_checked, cycles, brk, tg} = 160'h0;
      tick(2);
      rst_in <= 1'b0;
      tick(1);
      t_reset();
      t_profile();
      t_fill();
      t_event();
      t_breaks();
      t_begin();
      t_exec();
      give_verdict();
   end
endmodule
